// File: vofc_map.vh
/*
 * Register map, field positions, reset values and encodings of the valve
 * output fault configuration block.
 * Assumes one 32-bit Avalon-MM slave port with word-aligned byte addresses.
 */
`ifndef VOFC_MAP_VH
`define VOFC_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define VOFC_SYS_CFG 6'h00
`define VOFC_UNIT_CFG 6'h04
`define VOFC_OPEN_EN 6'h08
`define VOFC_ACTION 6'h0C
`define VOFC_IRQ_STAT 6'h10
`define VOFC_IRQ_CLR 6'h14
`define VOFC_IRQ_EN 6'h18
`define VOFC_UNIT_ERR 6'h1C
`define VOFC_OPEN_ERR 6'h20
`define VOFC_OUT_STATE 6'h24

// ****************************************
// field positions
// ****************************************
`define VOFC_SRC_SEL_BIT 0
`define VOFC_CTRL_MON_BIT 0
`define VOFC_OUT_MON_BIT 1
`define VOFC_SHORT_EN_BIT 2
`define VOFC_RECOV_BIT 3
`define VOFC_EV_CTRL 0
`define VOFC_EV_OUT 1
`define VOFC_EV_SHORT 2
`define VOFC_EV_OPEN 3
`define VOFC_EV_COMM 4
`define VOFC_EV_W 5

// ****************************************
// reset values and encodings
// ****************************************
`define VOFC_SYS_RST 1'h0
`define VOFC_UNIT_RST 4'h7
`define VOFC_ACT_CLEAR 2'h0
`define VOFC_ACT_HOLD 2'h1
`define VOFC_ACT_FORCE 2'h2

// comparator trip points in mV, set outside in the analog front end
`define VOFC_CTRL_HI_MV 26000
`define VOFC_CTRL_LO_MV 21000
`define VOFC_OUT_HI_MV 26000
`define VOFC_OUT_LO_MV 20000

`endif

// File: vofc_sync.v
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pin inputs and the core clock.
 */
`timescale 1ns/10ps
module vofc_sync
#(
   parameter W = 1
)
(
   input wire core_clk_i,
   input wire rst_i,
   input wire [W-1:0] pin_i,
   output reg [W-1:0] level_o
);

reg [W-1:0] s1;
reg [W-1:0] s2;
reg [W-1:0] s3;

// ****************************************
// stages; output moves when stages 2 and 3 agree
// ****************************************
always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      level_o <= {W{1'b0}};
   end
   else
   begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      level_o <= (s2 & s3) | (level_o & (s2 | s3));
   end
end

endmodule // vofc_sync

// File: vofc_chan.v
/*
 * One valve output channel with its communication fault action.
 * Assumes command and fault flag come from logic on the core clock.
 */
`timescale 1ns/10ps
`include "vofc_map.vh"
module vofc_chan
(
   input wire core_clk_i,
   input wire rst_i,
   input wire cmd_i,
   input wire comm_fault_i,
   input wire [1:0] action_i,
   output reg out_o
);

// ****************************************
// output stage
// ****************************************
always @(posedge core_clk_i)
begin
   if (rst_i)
      out_o <= 1'b0;
   else if (!comm_fault_i)
      out_o <= cmd_i;
   else
   begin
      case (action_i)
         `VOFC_ACT_HOLD: out_o <= out_o;
         `VOFC_ACT_FORCE: out_o <= 1'b1;
         default: out_o <= 1'b0;
      endcase
   end
end

endmodule // vofc_chan

// File: vofc_top.v
/*
 * Valve output fault supervision and communication fault output policy,
 * with parameters written by the network controller over Avalon-MM and by
 * a handheld terminal over a simple write strobe.
 * Assumes: handheld port, output commands and comm fault on the core clock;
 * supply comparators, short, open and switch inputs are asynchronous pins.
 */
`timescale 1ns/10ps
`include "vofc_map.vh"
module vofc_top
#(
   parameter NCH = 16
)
(
   input wire core_clk_i,
   input wire rst_i,
   input wire [5:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   output reg [31:0] avs_readdata_o,
   output reg avs_waitrequest_o,
   input wire ht_write_i,
   input wire [5:0] ht_address_i,
   input wire [31:0] ht_writedata_i,
   input wire ctrl_supply_over_i,
   input wire ctrl_supply_under_i,
   input wire out_supply_over_i,
   input wire out_supply_under_i,
   input wire short_det_i,
   input wire [NCH-1:0] open_det_i,
   input wire [1:0] switch_action_i,
   input wire comm_fault_i,
   input wire [NCH-1:0] out_cmd_i,
   output wire [NCH-1:0] valve_out_o,
   output reg [3:0] unit_err_o,
   output reg [NCH-1:0] open_err_o,
   output reg irq_o
);

// ****************************************
// declarations
// ****************************************
reg output_fault_source_select;
reg control_supply_monitor_enable;
reg output_supply_monitor_enable;
reg short_detect_enable;
reg short_recovery_mode;
reg [NCH-1:0] open_detect_enable;
reg [2*NCH-1:0] comm_fault_output_action;
reg [`VOFC_EV_W-1:0] irq_stat;
reg [`VOFC_EV_W-1:0] irq_en;
reg [`VOFC_EV_W-1:0] err_prev;
reg ctrl_err;
reg out_err;
reg short_err;
reg comm_prev;
reg [31:0] next_rdata;
reg [`VOFC_EV_W-1:0] next_stat;
reg [`VOFC_EV_W-1:0] clr_bits;
wire [3:0] sup_sync;
wire short_sync;
wire [NCH-1:0] open_sync;
wire [1:0] sw_sync;
wire bus_wr;
wire bus_rd;
wire [`VOFC_EV_W-1:0] err_now;
wire [`VOFC_EV_W-1:0] err_rise;

// ****************************************
// pin synchronisers
// ****************************************
vofc_sync #(.W(4)) u_sync_sup
(
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .pin_i({ctrl_supply_over_i, ctrl_supply_under_i,
           out_supply_over_i, out_supply_under_i}),
   .level_o(sup_sync)
);

vofc_sync #(.W(NCH + 3)) u_sync_misc
(
   .core_clk_i(core_clk_i),
   .rst_i(rst_i),
   .pin_i({short_det_i, switch_action_i, open_det_i}),
   .level_o({short_sync, sw_sync, open_sync})
);

// ****************************************
// avalon slave handshake
// ****************************************
// waitrequest drops for exactly one cycle; that edge takes the access
assign bus_wr = avs_write_i & ~avs_waitrequest_o;
assign bus_rd = avs_read_i & ~avs_waitrequest_o;

always @(posedge core_clk_i)
begin
   if (rst_i)
      avs_waitrequest_o <= 1'b1;
   else if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
   else
      avs_waitrequest_o <= 1'b1;
end

// ****************************************
// parameter registers
// ****************************************
// bus write applied first, handheld second: on a same-cycle clash to the
// same register the handheld value is the one left standing; a handheld write
// to any address outside its four registers holds irq_en over a bus write
always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      output_fault_source_select <= `VOFC_SYS_RST;
      {short_recovery_mode, short_detect_enable,
       output_supply_monitor_enable,
       control_supply_monitor_enable} <= `VOFC_UNIT_RST;
      open_detect_enable <= {NCH{1'b1}};
      comm_fault_output_action <= {2*NCH{1'b0}};
      irq_en <= {`VOFC_EV_W{1'b0}};
   end
   else
   begin
      if (bus_wr)
      begin
         case (avs_address_i)
            `VOFC_SYS_CFG:
               output_fault_source_select <=
                  avs_writedata_i[`VOFC_SRC_SEL_BIT];
            `VOFC_UNIT_CFG:
            begin
               control_supply_monitor_enable <=
                  avs_writedata_i[`VOFC_CTRL_MON_BIT];
               output_supply_monitor_enable <=
                  avs_writedata_i[`VOFC_OUT_MON_BIT];
               short_detect_enable <= avs_writedata_i[`VOFC_SHORT_EN_BIT];
               short_recovery_mode <= avs_writedata_i[`VOFC_RECOV_BIT];
            end
            `VOFC_OPEN_EN:
               open_detect_enable <= avs_writedata_i[NCH-1:0];
            `VOFC_ACTION:
               comm_fault_output_action <= avs_writedata_i[2*NCH-1:0];
            `VOFC_IRQ_EN:
               irq_en <= avs_writedata_i[`VOFC_EV_W-1:0];
            default:
               irq_en <= irq_en;
         endcase
      end
      if (ht_write_i)
      begin
         case (ht_address_i)
            `VOFC_SYS_CFG:
               output_fault_source_select <=
                  ht_writedata_i[`VOFC_SRC_SEL_BIT];
            `VOFC_UNIT_CFG:
            begin
               control_supply_monitor_enable <=
                  ht_writedata_i[`VOFC_CTRL_MON_BIT];
               output_supply_monitor_enable <=
                  ht_writedata_i[`VOFC_OUT_MON_BIT];
               short_detect_enable <= ht_writedata_i[`VOFC_SHORT_EN_BIT];
               short_recovery_mode <= ht_writedata_i[`VOFC_RECOV_BIT];
            end
            `VOFC_OPEN_EN:
               open_detect_enable <= ht_writedata_i[NCH-1:0];
            `VOFC_ACTION:
               comm_fault_output_action <= ht_writedata_i[2*NCH-1:0];
            default:
               irq_en <= irq_en;
         endcase
      end
   end
end

// ****************************************
// error flags
// ****************************************
always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      ctrl_err <= 1'b0;
      out_err <= 1'b0;
      short_err <= 1'b0;
      open_err_o <= {NCH{1'b0}};
   end
   else
   begin
      ctrl_err <= control_supply_monitor_enable
                  & (sup_sync[3] | sup_sync[2]);
      out_err <= output_supply_monitor_enable
                 & (sup_sync[1] | sup_sync[0]);
      if (short_recovery_mode)
         short_err <= short_err
                      | (short_detect_enable & short_sync);
      else
         short_err <= short_detect_enable & short_sync;
      open_err_o <= open_detect_enable & open_sync;
   end
end

// ****************************************
// readable unit status
// ****************************************
always @(posedge core_clk_i)
begin
   if (rst_i)
      unit_err_o <= 4'h0;
   else
      unit_err_o <= {comm_fault_i, short_err, out_err, ctrl_err};
end

// ****************************************
// interrupt status
// ****************************************
assign err_now = {comm_fault_i, |open_err_o, short_err, out_err, ctrl_err};
assign err_rise = err_now & ~err_prev;

always @*
begin
   clr_bits = {`VOFC_EV_W{1'b0}};
   if (bus_wr && avs_address_i == `VOFC_IRQ_CLR)
      clr_bits = avs_writedata_i[`VOFC_EV_W-1:0];
   // a new event in the clearing cycle survives
   next_stat = (irq_stat & ~clr_bits) | err_rise;
end

always @(posedge core_clk_i)
begin
   if (rst_i)
   begin
      err_prev <= {`VOFC_EV_W{1'b0}};
      irq_stat <= {`VOFC_EV_W{1'b0}};
      irq_o <= 1'b0;
   end
   else
   begin
      err_prev <= err_now;
      irq_stat <= next_stat;
      irq_o <= |(next_stat & irq_en);
   end
end

// ****************************************
// read data
// ****************************************
always @*
begin
   next_rdata = 32'h0;
   case (avs_address_i)
      `VOFC_SYS_CFG:
         next_rdata[`VOFC_SRC_SEL_BIT] = output_fault_source_select;
      `VOFC_UNIT_CFG:
         next_rdata[3:0] = {short_recovery_mode, short_detect_enable,
                            output_supply_monitor_enable,
                            control_supply_monitor_enable};
      `VOFC_OPEN_EN:
         next_rdata[NCH-1:0] = open_detect_enable;
      `VOFC_ACTION:
         next_rdata[2*NCH-1:0] = comm_fault_output_action;
      `VOFC_IRQ_STAT:
         next_rdata[`VOFC_EV_W-1:0] = irq_stat;
      `VOFC_IRQ_EN:
         next_rdata[`VOFC_EV_W-1:0] = irq_en;
      `VOFC_UNIT_ERR:
         next_rdata[3:0] = {comm_fault_i, short_err, out_err, ctrl_err};
      `VOFC_OPEN_ERR:
         next_rdata[NCH-1:0] = open_err_o;
      `VOFC_OUT_STATE:
         next_rdata[NCH-1:0] = valve_out_o;
      default:
         next_rdata = 32'h0;
   endcase
end

always @(posedge core_clk_i)
begin
   if (rst_i)
      avs_readdata_o <= 32'h0;
   else if (avs_read_i & avs_waitrequest_o)
      avs_readdata_o <= next_rdata;
end

// ****************************************
// output channels
// ****************************************
genvar g;
generate
   for (g = 0; g < NCH; g = g + 1)
   begin : g_ch
      wire [1:0] act;
      assign act = output_fault_source_select
                   ? comm_fault_output_action[2*g+1:2*g]
                   : sw_sync;
      vofc_chan u_chan
      (
         .core_clk_i(core_clk_i),
         .rst_i(rst_i),
         .cmd_i(out_cmd_i[g]),
         .comm_fault_i(comm_fault_i),
         .action_i(act),
         .out_o(valve_out_o[g])
      );
   end
endgenerate

endmodule // vofc_top

// File: vofc_properties.sv
/* Port assertions for vofc_top.
   Assumes one core clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module vofc_properties
#(
   parameter NCH = 16
)
(
   input wire core_clk_i,
   input wire rst_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_readdata_o,
   input wire avs_waitrequest_o,
   input wire ctrl_supply_over_i,
   input wire ctrl_supply_under_i,
   input wire out_supply_over_i,
   input wire out_supply_under_i,
   input wire [NCH-1:0] open_det_i,
   input wire comm_fault_i,
   input wire [NCH-1:0] out_cmd_i,
   input wire [NCH-1:0] valve_out_o,
   input wire [3:0] unit_err_o,
   input wire [NCH-1:0] open_err_o,
   input wire irq_o
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_pending;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_accept;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   a_one_wait: assert property (s_pending |=> s_accept)
      else $error("bus access not accepted after one wait");
   a_idle_wait: assert property (!(avs_read_i || avs_write_i)
      |=> avs_waitrequest_o) else $error("accept without request");
   a_rdata_hold: assert property (avs_waitrequest_o
      |-> $stable(avs_readdata_o)) else $error("read data moved");
   a_reset_quiet: assert property ($fell(rst_i) |->
      valve_out_o == 0 && unit_err_o == 0 && open_err_o == 0 && !irq_o)
      else $error("outputs not cleared by reset");
   a_out_follow: assert property (!comm_fault_i && !$past(comm_fault_i)
      && !$past(rst_i) |-> valve_out_o == $past(out_cmd_i))
      else $error("output does not follow command");
   a_comm_err: assert property ($rose(comm_fault_i)
      |-> ##[1:4] unit_err_o[3]) else $error("comm fault not flagged");
   a_open_quiet: assert property ((open_det_i == 0)[*8]
      |=> open_err_o == 0) else $error("open error without cause");
   a_ctrl_quiet: assert property ((!ctrl_supply_over_i &&
      !ctrl_supply_under_i)[*8] |=> !unit_err_o[0])
      else $error("control supply error without cause");
   a_outs_quiet: assert property ((!out_supply_over_i &&
      !out_supply_under_i)[*8] |=> !unit_err_o[1])
      else $error("output supply error without cause");
endmodule // vofc_properties

bind vofc_top vofc_properties #(.NCH(NCH)) u_props (.core_clk_i, .rst_i,
   .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
   .ctrl_supply_over_i, .ctrl_supply_under_i, .out_supply_over_i,
   .out_supply_under_i, .open_det_i, .comm_fault_i, .out_cmd_i,
   .valve_out_o, .unit_err_o, .open_err_o, .irq_o);

// File: vofc_ht_model.sv
/* Handheld terminal model: one-cycle parameter write strobes.
   Assumes the unit's core clock. */
`timescale 1ns/10ps
module vofc_ht_model
(
   input wire core_clk_i,
   output reg ht_write_o,
   output reg [5:0] ht_address_o,
   output reg [31:0] ht_writedata_o
);
   initial
   begin
      ht_write_o = 1'b0;
      ht_address_o = 6'h3F;
      ht_writedata_o = 32'h0;
   end
   task put(input [5:0] a, input [31:0] d);
      begin
         @(posedge core_clk_i);
         ht_write_o <= 1'b1;
         ht_address_o <= a;
         ht_writedata_o <= d;
         @(posedge core_clk_i);
         ht_write_o <= 1'b0;
         ht_address_o <= ~a;
         ht_writedata_o <= ~d;
      end
   endtask
endmodule // vofc_ht_model

// File: test_valve_output_fault_config.sv
/* Self-checking bench for vofc_top.
   Assumes the handheld model and the bound checker. */
`timescale 1ns/10ps
`include "vofc_map.vh"
module test_valve_output_fault_config;
   localparam NCH = 16;
   reg core_clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg [5:0] avs_address_i = 6'h0;
   reg avs_read_i = 1'b0, avs_write_i = 1'b0;
   reg [31:0] avs_writedata_i = 32'h0;
   wire [31:0] avs_readdata_o;
   wire avs_waitrequest_o, ht_write_i, irq_o;
   wire [5:0] ht_address_i;
   wire [31:0] ht_writedata_i;
   reg ctrl_supply_over_i = 1'b0, ctrl_supply_under_i = 1'b0;
   reg out_supply_over_i = 1'b0, out_supply_under_i = 1'b0;
   reg short_det_i = 1'b0, comm_fault_i = 1'b0;
   reg [NCH-1:0] open_det_i = 16'h0, out_cmd_i = 16'h0;
   reg [1:0] switch_action_i = 2'h0;
   wire [NCH-1:0] valve_out_o, open_err_o;
   wire [3:0] unit_err_o;
   integer miscompares = 0, samples_checked = 0, cycles = 0;
   reg [31:0] rd;
   always #2.5 core_clk_i = ~core_clk_i;
   vofc_top #(.NCH(NCH)) dut_u (.core_clk_i, .rst_i, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
      .avs_waitrequest_o, .ht_write_i, .ht_address_i, .ht_writedata_i,
      .ctrl_supply_over_i, .ctrl_supply_under_i, .out_supply_over_i,
      .out_supply_under_i, .short_det_i, .open_det_i, .switch_action_i,
      .comm_fault_i, .out_cmd_i, .valve_out_o, .unit_err_o, .open_err_o,
      .irq_o);
   vofc_ht_model ht_u (.core_clk_i, .ht_write_o(ht_write_i),
      .ht_address_o(ht_address_i), .ht_writedata_o(ht_writedata_i));
   task complete_run;
      begin
         $display("checked %0d bad %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task chk(input string what, input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   // one Avalon access; read data lands in rd
   task bus(input wr, input [5:0] a, input [31:0] d);
      integer n;
      begin
         n = 0;
         @(posedge core_clk_i);
         avs_address_i <= a;
         avs_writedata_i <= d;
         avs_write_i <= wr;
         avs_read_i <= !wr;
         @(posedge core_clk_i);
         while (avs_waitrequest_o !== 1'b0 && n < 20)
         begin
            n = n + 1;
            @(posedge core_clk_i);
         end
         if (n == 20)
            chk("accept", 1, 0);
         rd = avs_readdata_o;
         avs_read_i <= 1'b0;
         avs_write_i <= 1'b0;
      end
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge core_clk_i);
   endtask
   always @(posedge core_clk_i)
   begin
      cycles = cycles + 1;
      if (cycles == 3000)
      begin
         miscompares = miscompares + 1;
         complete_run;
      end
   end
   initial
   begin
      cyc(8);
      rst_i <= 1'b0;
      bus(0, `VOFC_SYS_CFG, 0);
      chk("sys_cfg", 0, rd);
      bus(0, `VOFC_UNIT_CFG, 0);
      chk("unit_cfg", 7, rd);
      bus(0, `VOFC_OPEN_EN, 0);
      chk("open_en", 32'hFFFF, rd);
      bus(0, `VOFC_ACTION, 0);
      chk("action", 0, rd);
      bus(0, 6'h3C, 0);
      chk("unmapped", 0, rd);
      bus(1, `VOFC_UNIT_CFG, 5);
      ht_u.put(`VOFC_UNIT_CFG, 3);
      bus(0, `VOFC_UNIT_CFG, 0);
      chk("ht last", 3, rd);
      ht_u.put(`VOFC_UNIT_CFG, 1);
      bus(1, `VOFC_UNIT_CFG, 6);
      bus(0, `VOFC_UNIT_CFG, 0);
      chk("bus last", 6, rd);
      ctrl_supply_under_i <= 1'b1;
      out_supply_under_i <= 1'b1;
      cyc(8);
      chk("ctrl off", 2, unit_err_o);
      bus(1, `VOFC_UNIT_CFG, 7);
      cyc(8);
      chk("supply err", 3, unit_err_o);
      bus(0, `VOFC_UNIT_ERR, 0);
      chk("unit_err reg", 3, rd);
      ctrl_supply_under_i <= 1'b0;
      out_supply_under_i <= 1'b0;
      bus(1, `VOFC_IRQ_EN, 4);
      short_det_i <= 1'b1;
      cyc(8);
      chk("short err", 4, unit_err_o);
      chk("irq up", 1, irq_o);
      short_det_i <= 1'b0;
      cyc(8);
      chk("short auto", 0, unit_err_o);
      bus(0, `VOFC_IRQ_STAT, 0);
      chk("irq stat", 4, rd & 32'h4);
      bus(1, `VOFC_IRQ_CLR, 4);
      cyc(2);
      chk("irq clr", 0, irq_o);
      bus(1, `VOFC_UNIT_CFG, 32'hF);
      short_det_i <= 1'b1;
      cyc(8);
      short_det_i <= 1'b0;
      cyc(8);
      chk("short manual", 4, unit_err_o);
      rst_i <= 1'b1;
      cyc(2);
      rst_i <= 1'b0;
      cyc(1);
      chk("short power", 0, unit_err_o);
      bus(1, `VOFC_UNIT_CFG, 3);
      short_det_i <= 1'b1;
      open_det_i <= 16'h0020;
      cyc(8);
      chk("short off", 0, unit_err_o);
      chk("open err", 32'h20, open_err_o);
      bus(0, `VOFC_OPEN_ERR, 0);
      chk("open_err reg", 32'h20, rd);
      short_det_i <= 1'b0;
      bus(1, `VOFC_OPEN_EN, 32'hFFDF);
      cyc(3);
      chk("open off", 0, open_err_o);
      open_det_i <= 16'h0;
      switch_action_i <= 2'h2;
      bus(1, `VOFC_SYS_CFG, 1);
      bus(1, `VOFC_ACTION, 32'h24);
      out_cmd_i <= 16'h0003;
      cyc(2);
      comm_fault_i <= 1'b1;
      out_cmd_i <= 16'h0;
      cyc(3);
      chk("per channel", 6, valve_out_o);
      chk("comm err", 8, unit_err_o & 4'h8);
      bus(0, `VOFC_OUT_STATE, 0);
      chk("out_state reg", 6, rd);
      bus(0, `VOFC_IRQ_STAT, 0);
      chk("irq events", 32'h18, rd & 32'h18);
      bus(1, `VOFC_ACTION, 32'h27);
      cyc(2);
      chk("code three", 6, valve_out_o);
      ht_u.put(`VOFC_SYS_CFG, 0);
      cyc(3);
      chk("switch force", 32'hFFFF, valve_out_o);
      switch_action_i <= 2'h1;
      cyc(8);
      chk("switch hold", 32'hFFFF, valve_out_o);
      switch_action_i <= 2'h0;
      cyc(8);
      chk("switch clear", 0, valve_out_o);
      comm_fault_i <= 1'b0;
      cyc(2);
      complete_run;
   end
endmodule // test_valve_output_fault_config
